// [rtl/hpc_pkg.sv]
`default_nettype none
package hpc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_POWER_AND_COMPOUND_CONFIG   = 8'h07;
  localparam logic [7:0] ADDR_PORT_NUMBERING_STRING_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_FIXED_PORT_MASK             = 8'h09;

  // ****************************************
  // Field positions and writable masks
  // ****************************************
  localparam int unsigned BIT_DYNAMIC_EN      = 7;
  localparam int unsigned BIT_OC_SEL_HI       = 5;
  localparam int unsigned BIT_OC_SEL_LO       = 4;
  localparam int unsigned BIT_COMPOUND        = 3;
  localparam int unsigned BIT_PORT_REMAP_EN   = 3;
  localparam int unsigned BIT_STRING_EN       = 0;
  localparam int unsigned BIT_FIXED_PORT_LO   = 1;
  localparam int unsigned BIT_FIXED_PORT_HI   = 4;
  localparam logic [7:0]  MASK_POWER_CFG      = 8'hB8;
  localparam logic [7:0]  MASK_NUMBERING_CFG  = 8'h09;
  localparam logic [7:0]  MASK_FIXED_PORTS    = 8'h1E;
  localparam logic [7:0]  RESET_CFG           = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED       = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLOCK_PERIOD_NS     = 4;
  localparam int unsigned OC_DELAY0_US_X10    = 1;
  localparam int unsigned OC_DELAY1_US_X10    = 40;
  localparam int unsigned OC_DELAY2_US_X10    = 80;
  localparam int unsigned OC_DELAY3_US_X10    = 160;
  localparam int unsigned NS_PER_MS_X10       = 100000;
  localparam int unsigned DROP_TIME_NS        = 1000;
  localparam int unsigned DROP_CYCLES         = DROP_TIME_NS / CLOCK_PERIOD_NS;
  localparam int unsigned OC_CNT_W            = 22;
  localparam int unsigned DROP_CNT_W          = 9;

  localparam logic [1:0]  OC_SEL_0P1          = 2'h0;
  localparam logic [1:0]  OC_SEL_4P0          = 2'h1;
  localparam logic [1:0]  OC_SEL_8P0          = 2'h2;
  localparam logic [1:0]  OC_SEL_16P0         = 2'h3;

  localparam int unsigned NUM_PORTS           = 4;

  typedef enum logic [2:0] {
    HPC_RUN    = 3'b001,
    HPC_DROP   = 3'b010,
    HPC_ATTACH = 3'b100
  } hpc_pwr_e;

endpackage
`default_nettype wire

// [rtl/hpc_power_port_config.sv]
`default_nettype none
// Behaviour
// - Byte-two bit 7 enables automatic self/bus power switching; clear means none.
// - With switching enabled, the local supply sense input is watched every cycle in the run state only.
// - A supply change disconnects and unpowers all downstream ports at once.
// - The same change also drops the upstream connection.
// - Reattach upstream as bus-powered without supply, self-powered with supply.
// - Bits 5:4 pick over-current delay 0.1, 4.0, 8.0 or 16.0 ms.
// - Byte-two bit 3 reports compound device membership.
// - In strap configuration any non-removable port forces compound reporting.
// - Byte-three bit 3 selects standard (0) or port remapping (1) numbering.
// - Byte-three bit 0 enables string descriptors; clear gives none.
// - Mask bits 1..4 mark ports 1..4 non-removable; others reserved.
// - In default configuration the two straps decide non-removable ports.
// - With switching enabled, the byte-one power select bit is ignored.
module hpc_power_port_config #(
  parameter int unsigned OC_CYC0 = hpc_pkg::OC_DELAY0_US_X10 * hpc_pkg::NS_PER_MS_X10
                                   / hpc_pkg::CLOCK_PERIOD_NS,
  parameter int unsigned OC_CYC1 = hpc_pkg::OC_DELAY1_US_X10 * hpc_pkg::NS_PER_MS_X10
                                   / hpc_pkg::CLOCK_PERIOD_NS,
  parameter int unsigned OC_CYC2 = hpc_pkg::OC_DELAY2_US_X10 * hpc_pkg::NS_PER_MS_X10
                                   / hpc_pkg::CLOCK_PERIOD_NS,
  parameter int unsigned OC_CYC3 = hpc_pkg::OC_DELAY3_US_X10 * hpc_pkg::NS_PER_MS_X10
                                   / hpc_pkg::CLOCK_PERIOD_NS
) (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_cfg_wr,
  input  wire logic [7:0] i_cfg_addr,
  input  wire logic [7:0] i_cfg_wdata,
  input  wire logic       i_use_defaults,
  input  wire logic [1:0] i_fixed_port_straps,
  input  wire logic       i_local_supply_sense,
  input  wire logic       i_self_power_sel,
  input  wire logic       i_overcurrent,
  output var  logic [7:0] o_cfg_rdata,
  output var  logic       o_self_powered,
  output var  logic       o_upstream_connect,
  output var  logic       o_ds_connect,
  output var  logic       o_port_power_en,
  output var  logic       o_compound,
  output var  logic       o_port_remap_en,
  output var  logic       o_string_en,
  output var  logic [3:0] o_fixed_ports,
  output var  logic       o_overcurrent_flag
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] pwr_cfg_q;
  logic [7:0] pwr_cfg_d;
  logic [7:0] num_cfg_q;
  logic [7:0] num_cfg_d;
  logic [7:0] fix_cfg_q;
  logic [7:0] fix_cfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb
  begin
    pwr_cfg_d = pwr_cfg_q;
    num_cfg_d = num_cfg_q;
    fix_cfg_d = fix_cfg_q;
    if (i_cfg_wr && (i_cfg_addr == hpc_pkg::ADDR_POWER_AND_COMPOUND_CONFIG))
    begin
      pwr_cfg_d = i_cfg_wdata & hpc_pkg::MASK_POWER_CFG;
    end
    if (i_cfg_wr && (i_cfg_addr == hpc_pkg::ADDR_PORT_NUMBERING_STRING_CONFIG))
    begin
      num_cfg_d = i_cfg_wdata & hpc_pkg::MASK_NUMBERING_CFG;
    end
    if (i_cfg_wr && (i_cfg_addr == hpc_pkg::ADDR_FIXED_PORT_MASK))
    begin
      fix_cfg_d = i_cfg_wdata & hpc_pkg::MASK_FIXED_PORTS;
    end
    unique case (i_cfg_addr)
      hpc_pkg::ADDR_POWER_AND_COMPOUND_CONFIG:    rdata_d = pwr_cfg_q;
      hpc_pkg::ADDR_PORT_NUMBERING_STRING_CONFIG: rdata_d = num_cfg_q;
      hpc_pkg::ADDR_FIXED_PORT_MASK:              rdata_d = fix_cfg_q;
      default:                                    rdata_d = hpc_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pwr_cfg_q <= hpc_pkg::RESET_CFG;
      num_cfg_q <= hpc_pkg::RESET_CFG;
      fix_cfg_q <= hpc_pkg::RESET_CFG;
      rdata_q   <= hpc_pkg::RESET_CFG;
    end
    else
    begin
      pwr_cfg_q <= pwr_cfg_d;
      num_cfg_q <= num_cfg_d;
      fix_cfg_q <= fix_cfg_d;
      rdata_q   <= rdata_d;
    end
  end

  // ****************************************
  // Non-removable ports and descriptor flags
  // ****************************************
  logic       dyn_en;
  logic [1:0] oc_sel;
  logic [3:0] strap_ports;
  logic [3:0] fixed_d;
  logic [3:0] fixed_q;
  logic       compound_d;
  logic       compound_q;
  logic       remap_q;
  logic       string_q;

  assign dyn_en = pwr_cfg_q[hpc_pkg::BIT_DYNAMIC_EN];
  assign oc_sel = pwr_cfg_q[hpc_pkg::BIT_OC_SEL_HI:hpc_pkg::BIT_OC_SEL_LO];

  // Strap value n marks ports 1..n as non-removable
  genvar gp;
  generate
    for (gp = 0; gp < hpc_pkg::NUM_PORTS; gp++)
    begin : g_strap
      assign strap_ports[gp] = ({1'b0, i_fixed_port_straps} > 3'(gp));
    end
  endgenerate

  always_comb
  begin
    if (i_use_defaults)
    begin
      fixed_d    = strap_ports;
      compound_d = |strap_ports;
    end
    else
    begin
      fixed_d    = fix_cfg_q[hpc_pkg::BIT_FIXED_PORT_HI:hpc_pkg::BIT_FIXED_PORT_LO];
      compound_d = pwr_cfg_q[hpc_pkg::BIT_COMPOUND];
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      fixed_q    <= '0;
      compound_q <= 1'b0;
      remap_q    <= 1'b0;
      string_q   <= 1'b0;
    end
    else
    begin
      fixed_q    <= fixed_d;
      compound_q <= compound_d;
      remap_q    <= num_cfg_q[hpc_pkg::BIT_PORT_REMAP_EN];
      string_q   <= num_cfg_q[hpc_pkg::BIT_STRING_EN];
    end
  end

  // ****************************************
  // Dynamic power switching
  // ****************************************
  hpc_pkg::hpc_pwr_e              st_q;
  hpc_pkg::hpc_pwr_e              st_d;
  logic                           supply_q;
  logic                           self_q;
  logic                           self_d;
  logic [hpc_pkg::DROP_CNT_W-1:0] drop_q;
  logic [hpc_pkg::DROP_CNT_W-1:0] drop_d;
  logic                           up_d;
  logic                           up_q;
  logic                           ds_d;
  logic                           ds_q;

  always_comb
  begin
    st_d   = st_q;
    self_d = self_q;
    drop_d = drop_q;
    up_d   = 1'b1;
    ds_d   = 1'b1;
    unique case (st_q)
      hpc_pkg::HPC_RUN:
      begin
        if (dyn_en && (i_local_supply_sense != supply_q))
        begin
          st_d   = hpc_pkg::HPC_DROP;
          drop_d = hpc_pkg::DROP_CNT_W'(hpc_pkg::DROP_CYCLES - 1);
          up_d   = 1'b0;
          ds_d   = 1'b0;
        end
        else if (!dyn_en)
        begin
          self_d = i_self_power_sel;
        end
      end
      hpc_pkg::HPC_DROP:
      begin
        up_d = 1'b0;
        ds_d = 1'b0;
        if (drop_q == '0)
        begin
          st_d = hpc_pkg::HPC_ATTACH;
        end
        else
        begin
          drop_d = drop_q - 1'b1;
        end
      end
      hpc_pkg::HPC_ATTACH:
      begin
        self_d = supply_q;
        st_d   = hpc_pkg::HPC_RUN;
      end
      default:
      begin
        st_d = hpc_pkg::HPC_RUN;
        up_d = 1'b0;
        ds_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q     <= hpc_pkg::HPC_RUN;
      supply_q <= 1'b0;
      self_q   <= 1'b0;
      drop_q   <= '0;
      up_q     <= 1'b0;
      ds_q     <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      supply_q <= i_local_supply_sense;
      self_q   <= self_d;
      drop_q   <= drop_d;
      up_q     <= up_d;
      ds_q     <= ds_d;
    end
  end

  // ****************************************
  // Over-current qualification
  // ****************************************
  logic [hpc_pkg::OC_CNT_W-1:0] oc_lim;
  logic [hpc_pkg::OC_CNT_W-1:0] oc_cnt_q;
  logic [hpc_pkg::OC_CNT_W-1:0] oc_cnt_d;
  logic                         oc_flag_q;
  logic                         oc_flag_d;

  always_comb
  begin
    unique case (oc_sel)
      hpc_pkg::OC_SEL_0P1:  oc_lim = hpc_pkg::OC_CNT_W'(OC_CYC0);
      hpc_pkg::OC_SEL_4P0:  oc_lim = hpc_pkg::OC_CNT_W'(OC_CYC1);
      hpc_pkg::OC_SEL_8P0:  oc_lim = hpc_pkg::OC_CNT_W'(OC_CYC2);
      hpc_pkg::OC_SEL_16P0: oc_lim = hpc_pkg::OC_CNT_W'(OC_CYC3);
    endcase
    oc_cnt_d  = oc_cnt_q;
    oc_flag_d = 1'b0;
    if (!i_overcurrent)
    begin
      oc_cnt_d = '0;
    end
    else if (oc_cnt_q >= oc_lim)
    begin
      oc_flag_d = 1'b1;
    end
    else
    begin
      oc_cnt_d = oc_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      oc_cnt_q  <= '0;
      oc_flag_q <= 1'b0;
    end
    else
    begin
      oc_cnt_q  <= oc_cnt_d;
      oc_flag_q <= oc_flag_d;
    end
  end

  assign o_cfg_rdata        = rdata_q;
  assign o_self_powered     = self_q;
  assign o_upstream_connect = up_q;
  assign o_ds_connect       = ds_q;
  assign o_port_power_en    = ds_q;
  assign o_compound         = compound_q;
  assign o_port_remap_en    = remap_q;
  assign o_string_en        = string_q;
  assign o_fixed_ports      = fixed_q;
  assign o_overcurrent_flag = oc_flag_q;

endmodule
`default_nettype wire

// [testbench/hpc_power_port_config_props.sv]
`default_nettype none
module hpc_power_port_config_props #(
  parameter int unsigned OC_CYC0 = 4,
  parameter int unsigned OC_CYC1 = 8,
  parameter int unsigned OC_CYC2 = 16,
  parameter int unsigned OC_CYC3 = 32
) (
  input wire logic       i_clock,
  input wire logic       i_rstn,
  input wire logic       i_cfg_wr,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] i_cfg_wdata,
  input wire logic       i_use_defaults,
  input wire logic [1:0] i_fixed_port_straps,
  input wire logic       i_local_supply_sense,
  input wire logic       i_self_power_sel,
  input wire logic       i_overcurrent,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic       o_self_powered,
  input wire logic       o_upstream_connect,
  input wire logic       o_ds_connect,
  input wire logic       o_port_power_en,
  input wire logic       o_compound,
  input wire logic       o_port_remap_en,
  input wire logic       o_string_en,
  input wire logic [3:0] o_fixed_ports,
  input wire logic       o_overcurrent_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] s7_q, s8_q, s9_q, cnt_q, rd, lim;
  logic [3:0] e_fix;
  logic       e_cmp;
  // ****************************************
  // Shadow registers and counters
  // ****************************************
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      s7_q <= 8'h00;
      s8_q <= 8'h00;
      s9_q <= 8'h00;
      cnt_q <= 8'h00;
    end
    else
    begin
      cnt_q <= !i_overcurrent ? 8'h00 : cnt_q + 8'(cnt_q != 8'hFF);
      if (i_cfg_wr && i_cfg_addr == hpc_pkg::ADDR_POWER_AND_COMPOUND_CONFIG)
        s7_q <= i_cfg_wdata & hpc_pkg::MASK_POWER_CFG;
      if (i_cfg_wr && i_cfg_addr == hpc_pkg::ADDR_PORT_NUMBERING_STRING_CONFIG)
        s8_q <= i_cfg_wdata & hpc_pkg::MASK_NUMBERING_CFG;
      if (i_cfg_wr && i_cfg_addr == hpc_pkg::ADDR_FIXED_PORT_MASK)
        s9_q <= i_cfg_wdata & hpc_pkg::MASK_FIXED_PORTS;
    end
  end
  always_comb
  begin
    rd = i_cfg_addr == hpc_pkg::ADDR_POWER_AND_COMPOUND_CONFIG ? s7_q :
         i_cfg_addr == hpc_pkg::ADDR_PORT_NUMBERING_STRING_CONFIG ? s8_q :
         i_cfg_addr == hpc_pkg::ADDR_FIXED_PORT_MASK ? s9_q : hpc_pkg::READ_UNMAPPED;
    lim = s7_q[5:4] == 2'h0 ? 8'(OC_CYC0) : s7_q[5:4] == 2'h1 ? 8'(OC_CYC1) :
          s7_q[5:4] == 2'h2 ? 8'(OC_CYC2) : 8'(OC_CYC3);
    e_fix = i_use_defaults ? (4'h1 << i_fixed_port_straps) - 4'h1 : s9_q[4:1];
    e_cmp = i_use_defaults ? (i_fixed_port_straps != 2'h0) : s7_q[3];
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  a_rdata_shadow: assert property (o_cfg_rdata == $past(rd))
    else $error("read data differs from register contents");
  a_drop_on_change: assert property (s7_q[7] && o_upstream_connect && $past(o_upstream_connect)
    && $changed(i_local_supply_sense) |=> !o_upstream_connect && !o_ds_connect && !o_port_power_en)
    else $error("supply change did not drop the connections");
  a_drop_length: assert property ($fell(o_upstream_connect) |-> ##250 !o_upstream_connect
    ##1 o_upstream_connect) else $error("disconnect span wrong");
  a_reattach_mode: assert property ($rose(o_upstream_connect) && $past(i_rstn) && s7_q[7]
    |-> o_ds_connect && o_port_power_en && o_self_powered == $past(i_local_supply_sense, 2))
    else $error("reattach mode does not follow supply");
  a_static_mode: assert property ($past(i_rstn) && !$past(s7_q[7])
    |-> o_self_powered == $past(i_self_power_sel) && !$fell(o_upstream_connect))
    else $error("static power mode wrong");
  a_oc_min_time: assert property ($rose(o_overcurrent_flag) |-> cnt_q > lim)
    else $error("over-current flagged too early");
  a_oc_hold: assert property (o_overcurrent_flag |-> $past(i_overcurrent))
    else $error("over-current flag without input");
  a_compound_rep: assert property ($stable(i_use_defaults) && $stable(i_fixed_port_straps)
    |=> o_compound == $past(e_cmp)) else $error("compound report wrong");
  a_fixed_ports: assert property ($stable(i_use_defaults) && $stable(i_fixed_port_straps)
    |=> o_fixed_ports == $past(e_fix)) else $error("fixed port report wrong");
  a_byte3_out: assert property (!i_use_defaults
    |=> {o_port_remap_en, o_string_en} == $past({s8_q[3], s8_q[0]}))
    else $error("numbering or string output wrong");
endmodule
`default_nettype wire

// [testbench/hpc_cfg_master.sv]
`default_nettype none
module hpc_cfg_master (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  output var  logic       o_wr,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_wr = 1'h0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_wr = 1'h1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clock);
    o_wr = 1'h0;
    o_wdata = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    o_addr = a;
    @(negedge i_clock);
    d = i_rdata;
  endtask
  // Compound set together with its fixed ports
  task automatic set_compound(input logic [3:0] ports);
    write(hpc_pkg::ADDR_FIXED_PORT_MASK, {3'h0, ports, 1'h0});
    write(hpc_pkg::ADDR_POWER_AND_COMPOUND_CONFIG, 8'h08);
  endtask
endmodule
`default_nettype wire

// [testbench/hpc_power_port_config_tb_top.sv]
`default_nettype none
module hpc_power_port_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM [4] = '{4, 8, 16, 32};
  localparam logic [7:0] RA [4] = '{8'h07, 8'h08, 8'h09, 8'h0A};
  localparam logic [7:0] RE [4] = '{hpc_pkg::MASK_POWER_CFG, hpc_pkg::MASK_NUMBERING_CFG,
                                    hpc_pkg::MASK_FIXED_PORTS, hpc_pkg::READ_UNMAPPED};
  logic       i_clock, i_rstn, i_cfg_wr, i_use_defaults, i_local_supply_sense;
  logic       i_self_power_sel, i_overcurrent, o_self_powered, o_upstream_connect;
  logic       o_ds_connect, o_port_power_en, o_compound, o_port_remap_en, o_string_en;
  logic       o_overcurrent_flag;
  logic [1:0] i_fixed_port_straps;
  logic [3:0] o_fixed_ports;
  logic [7:0] i_cfg_addr, i_cfg_wdata, o_cfg_rdata;
  int         err_total, n_tests;
  hpc_power_port_config #(.OC_CYC0(LIM[0]), .OC_CYC1(LIM[1]), .OC_CYC2(LIM[2]),
    .OC_CYC3(LIM[3])) i_hpc_power_port_config (.*);
  hpc_cfg_master i_hpc_cfg_master (.i_clock(i_clock), .i_rdata(o_cfg_rdata),
    .o_wr(i_cfg_wr), .o_addr(i_cfg_addr), .o_wdata(i_cfg_wdata));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    i_clock = 1'h0;
    forever #2 i_clock = ~i_clock;
  end
  initial
  begin
    #20000;
    err_total++;
    stop_test();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    logic [7:0] d;
    err_total = 0;
    n_tests = 0;
    {i_rstn, i_use_defaults, i_fixed_port_straps, i_local_supply_sense} = 5'h00;
    {i_self_power_sel, i_overcurrent} = 2'h0;
    repeat (10) @(negedge i_clock);
    i_rstn = 1'h1;
    foreach (RA[k]) i_hpc_cfg_master.write(RA[k], 8'hFF);
    foreach (RA[k])
    begin
      i_hpc_cfg_master.read(RA[k], d);
      chk(d, RE[k]);
    end
    chk({o_compound, o_port_remap_en, o_string_en, o_fixed_ports}, 8'h7F);
    i_hpc_cfg_master.write(8'h07, 8'h00);
    i_hpc_cfg_master.write(8'h08, 8'h00);
    i_hpc_cfg_master.write(8'h09, 8'h0A);
    repeat (2) @(negedge i_clock);
    chk({o_compound, o_port_remap_en, o_string_en, o_fixed_ports}, 8'h05);
    i_hpc_cfg_master.write(8'h08, 8'h08);
    repeat (2) @(negedge i_clock);
    chk({o_port_remap_en, o_string_en}, 8'h02);
    i_use_defaults = 1'h1;
    for (int n = 0; n < 4; n++)
    begin
      i_fixed_port_straps = n[1:0];
      repeat (3) @(negedge i_clock);
      chk({o_compound, o_fixed_ports}, (n != 0 ? 8'h10 : 8'h00) | ((8'h01 << n) - 8'h01));
    end
    i_use_defaults = 1'h0;
    i_hpc_cfg_master.set_compound(4'h6);
    repeat (2) @(negedge i_clock);
    chk({o_compound, o_fixed_ports}, 8'h16);
    i_self_power_sel = 1'h1;
    i_local_supply_sense = 1'h1;
    repeat (3) @(negedge i_clock);
    chk({o_upstream_connect, o_ds_connect, o_port_power_en, o_self_powered}, 8'h0F);
    i_hpc_cfg_master.write(8'h07, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      i_local_supply_sense = ~i_local_supply_sense;
      repeat (2) @(negedge i_clock);
      chk({o_upstream_connect, o_ds_connect, o_port_power_en}, 8'h00);
      repeat (252) @(negedge i_clock);
      chk({o_upstream_connect, o_ds_connect, o_port_power_en, o_self_powered},
          {4'h0, 3'h7, i_local_supply_sense});
    end
    for (int k = 0; k < 4; k++)
    begin
      i_hpc_cfg_master.write(8'h07, {2'h0, k[1:0], 4'h0});
      i_overcurrent = 1'h1;
      repeat (LIM[k] - 1) @(negedge i_clock);
      chk(o_overcurrent_flag, 8'h00);
      repeat (2) @(negedge i_clock);
      chk(o_overcurrent_flag, 8'h01);
      i_overcurrent = 1'h0;
      repeat (2) @(negedge i_clock);
      chk(o_overcurrent_flag, 8'h00);
    end
    stop_test();
  end
endmodule
bind hpc_power_port_config hpc_power_port_config_props #(.OC_CYC0(OC_CYC0), .OC_CYC1(OC_CYC1),
  .OC_CYC2(OC_CYC2), .OC_CYC3(OC_CYC3)) i_hpc_power_port_config_props (.*);
`default_nettype wire
